// >>> design/rct_pkg.sv
// Purpose: shared constants for the reset cause tracking block
// Assumes: one 8-bit control register plus interrupt status and mask
// Notes: register offsets are word indices on the plain register port
package rct_pkg;
    // ****************************************
    // register map
    // ****************************************
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_IRQ_STATUS = 4'h1;
    localparam logic [3:0] ADDR_IRQ_MASK = 4'h2;
    localparam logic [3:0] ADDR_CAUSE = 4'h3;
    // ****************************************
    // field positions of the control register
    // ****************************************
    localparam int BIT_BROWNOUT = 0;
    localparam int BIT_POWERON = 1;
    localparam int BIT_POWERDOWN = 2;
    localparam int BIT_WDT_TIMEOUT = 3;
    localparam int BIT_RESET_INSTR = 4;
    localparam int BIT_SOFT_BOR = 6;
    localparam int BIT_PRIO_EN = 7;
    localparam int NUM_CAUSES = 8;
    // ****************************************
    // reset values and encodings
    // ****************************************
    localparam logic [1:0] BOR_MODE_OFF = 2'h0;
    localparam logic [1:0] BOR_MODE_SOFT = 2'h1;
    localparam logic [1:0] BOR_MODE_NOSLEEP = 2'h2;
    localparam logic [1:0] BOR_MODE_ON = 2'h3;
    localparam logic RST_PRIO_EN = 1'h0;
    localparam logic RST_RESET_INSTR = 1'h1;
    localparam logic RST_WDT_TIMEOUT = 1'h1;
    localparam logic RST_POWERDOWN = 1'h1;
    localparam logic RST_POWERON = 1'h0;
    localparam logic RST_BROWNOUT = 1'h0;
    localparam logic [7:0] RST_IRQ_MASK = 8'h00;
    // cause index: bit position in the cause status register
    typedef enum logic [2:0] {
        CAUSE_POWERON,
        CAUSE_PIN_NORMAL,
        CAUSE_PIN_PWRMGD,
        CAUSE_WATCHDOG,
        CAUSE_BROWNOUT,
        CAUSE_INSTR,
        CAUSE_STACK_FULL,
        CAUSE_STACK_UNDER
    } rct_cause_e;
endpackage

// >>> design/rct_sticky.sv
// Purpose: bank of sticky event bits, set by hardware, cleared by writing 1
// Assumes: set and clear in the same cycle keep the bit set
// Notes: read data registered; one generate loop over the bits
`timescale 1ns/1ns
`default_nettype none
module rct_sticky (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic [7:0] set_evt,
    input wire logic clr_wr,
    input wire logic [7:0] clr_data,
    output logic [7:0] bits_q
);
    // ****************************************
    // per-bit sticky storage
    // ****************************************
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_bit
            // set wins over a simultaneous clear
            always_ff @(posedge clk_sys or negedge rstn) begin
                if (!rstn) begin
                    bits_q[gi] <= 1'h0;
                end else if (set_evt[gi]) begin
                    bits_q[gi] <= 1'h1;
                end else if (clr_wr && clr_data[gi]) begin
                    bits_q[gi] <= 1'h0;
                end
            end
        end
    endgenerate
endmodule // rct_sticky
`default_nettype wire

// >>> design/rct_reset_track.sv
// Purpose: reset-cause flags and reset control register
// Assumes: event inputs are one-cycle pulses from the reset sources;
//          the flags survive resets other than the power-on one
// Notes: rstn is the power-on reset; the other resets arrive as events
`timescale 1ns/1ns
`default_nettype none
module rct_reset_track (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic [1:0] brownout_mode_cfg,
    input wire logic sleep_mode,
    input wire logic evt_pin_reset,
    input wire logic evt_watchdog_reset,
    input wire logic evt_watchdog_timeout,
    input wire logic evt_brownout_reset,
    input wire logic evt_reset_instr,
    input wire logic evt_stack_full,
    input wire logic evt_stack_under,
    input wire logic evt_watchdog_clear_instr,
    input wire logic evt_sleep_instr,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    output logic priority_levels_enable,
    output logic brownout_detect_en,
    output logic irq
);
    // ****************************************
    // state
    // ****************************************
    logic prio_en_r;
    logic soft_bor_r;
    logic reset_instr_flag_r;
    logic watchdog_timeout_flag_r;
    logic powerdown_flag_r;
    logic poweron_flag_r;
    logic brownout_flag_r;
    logic [7:0] irq_mask_r;
    logic [7:0] irq_status;
    logic [7:0] cause_evt;
    logic [7:0] ctrl_view;
    logic [7:0] rdata_nxt;
    logic soft_mode;
    logic bor_active;
    logic first_cycle_r;
    logic wr_ctrl;
    logic wr_stat;

    assign soft_mode = (brownout_mode_cfg == rct_pkg::BOR_MODE_SOFT);
    assign wr_ctrl = reg_wr && (reg_addr == rct_pkg::ADDR_CTRL);
    assign wr_stat = reg_wr && (reg_addr == rct_pkg::ADDR_IRQ_STATUS);
    // detection is on per mode; mode 10 drops it while asleep
    // soft enable gating
    always_comb begin
        case (brownout_mode_cfg)
            rct_pkg::BOR_MODE_OFF: bor_active = 1'h0;
            rct_pkg::BOR_MODE_SOFT: bor_active = soft_bor_r;
            rct_pkg::BOR_MODE_NOSLEEP: bor_active = !sleep_mode;
            default: bor_active = 1'h1;
        endcase
    end

    // ****************************************
    // cause events
    // ****************************************
    // eight causes decoded; power-on shows once after release
    always_comb begin
        cause_evt = 8'h00;
        cause_evt[rct_pkg::CAUSE_POWERON] = first_cycle_r;
        cause_evt[rct_pkg::CAUSE_PIN_NORMAL] = evt_pin_reset && !sleep_mode;
        cause_evt[rct_pkg::CAUSE_PIN_PWRMGD] = evt_pin_reset && sleep_mode;
        cause_evt[rct_pkg::CAUSE_WATCHDOG] = evt_watchdog_reset;
        cause_evt[rct_pkg::CAUSE_BROWNOUT] = evt_brownout_reset
                                             && bor_active;
        cause_evt[rct_pkg::CAUSE_INSTR] = evt_reset_instr;
        cause_evt[rct_pkg::CAUSE_STACK_FULL] = evt_stack_full;
        cause_evt[rct_pkg::CAUSE_STACK_UNDER] = evt_stack_under;
    end

    // marks the first cycle after power-on reset release
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            first_cycle_r <= 1'h1;
        end else begin
            first_cycle_r <= 1'h0;
        end
    end

    // sticky interrupt status, write one to clear
    rct_sticky u_status (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .set_evt(cause_evt),
        .clr_wr(wr_stat),
        .clr_data(reg_wdata),
        .bits_q(irq_status)
    );

    // ****************************************
    // control bits
    // ****************************************
    // priority enable
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            prio_en_r <= rct_pkg::RST_PRIO_EN;
        end else if (wr_ctrl) begin
            prio_en_r <= reg_wdata[rct_pkg::BIT_PRIO_EN];
        end
    end

    // reset value follows mode; strap caught after release, not in reset
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            soft_bor_r <= 1'h0;
        end else if (first_cycle_r) begin
            soft_bor_r <= soft_mode;
        end else if (wr_ctrl && soft_mode) begin
            soft_bor_r <= reg_wdata[rct_pkg::BIT_SOFT_BOR];
        end
    end

    // ****************************************
    // reset-event flags
    // ****************************************
    // reset instruction clears, software sets; event beats write
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            reset_instr_flag_r <= rct_pkg::RST_RESET_INSTR;
        end else if (evt_reset_instr) begin
            reset_instr_flag_r <= 1'h0;
        end else if (wr_ctrl) begin
            reset_instr_flag_r <= reg_wdata[rct_pkg::BIT_RESET_INSTR];
        end
    end

    // timeout clears; clear or sleep instr sets; read-only
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            watchdog_timeout_flag_r <= rct_pkg::RST_WDT_TIMEOUT;
        end else if (evt_watchdog_timeout || evt_watchdog_reset) begin
            watchdog_timeout_flag_r <= 1'h0;
        end else if (evt_watchdog_clear_instr || evt_sleep_instr) begin
            watchdog_timeout_flag_r <= 1'h1;
        end
    end

    // sleep clears, watchdog clear sets; read-only
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            powerdown_flag_r <= rct_pkg::RST_POWERDOWN;
        end else if (evt_sleep_instr) begin
            powerdown_flag_r <= 1'h0;
        end else if (evt_watchdog_clear_instr) begin
            powerdown_flag_r <= 1'h1;
        end
    end

    // cleared by power-on reset or by a software write, set only by software
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            poweron_flag_r <= rct_pkg::RST_POWERON;
        end else if (wr_ctrl) begin
            poweron_flag_r <= reg_wdata[rct_pkg::BIT_POWERON];
        end
    end

    // brown-out clears flag only while detection is active
    // flag pair lets software tell brown-out from power-on
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            brownout_flag_r <= rct_pkg::RST_BROWNOUT;
        end else if (evt_brownout_reset && bor_active) begin
            brownout_flag_r <= 1'h0;
        end else if (wr_ctrl) begin
            brownout_flag_r <= reg_wdata[rct_pkg::BIT_BROWNOUT];
        end
    end

    // ****************************************
    // register read path
    // ****************************************
    // low five bits are flags; bit 6 zero outside mode 01
    // all flags read in one word
    always_comb begin
        ctrl_view = 8'h00;
        ctrl_view[rct_pkg::BIT_PRIO_EN] = prio_en_r;
        ctrl_view[rct_pkg::BIT_SOFT_BOR] = soft_bor_r && soft_mode;
        ctrl_view[rct_pkg::BIT_RESET_INSTR] = reset_instr_flag_r;
        ctrl_view[rct_pkg::BIT_WDT_TIMEOUT] = watchdog_timeout_flag_r;
        ctrl_view[rct_pkg::BIT_POWERDOWN] = powerdown_flag_r;
        ctrl_view[rct_pkg::BIT_POWERON] = poweron_flag_r;
        ctrl_view[rct_pkg::BIT_BROWNOUT] = brownout_flag_r;
    end

    // unmapped addresses read zero
    always_comb begin
        if (reg_addr == rct_pkg::ADDR_CTRL) begin
            rdata_nxt = ctrl_view;
        end else if (reg_addr == rct_pkg::ADDR_IRQ_STATUS) begin
            rdata_nxt = irq_status;
        end else if (reg_addr == rct_pkg::ADDR_IRQ_MASK) begin
            rdata_nxt = irq_mask_r;
        end else if (reg_addr == rct_pkg::ADDR_CAUSE) begin
            rdata_nxt = irq_status;
        end else begin
            rdata_nxt = 8'h00;
        end
    end

    // read data valid only the cycle after the strobe
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata <= rdata_nxt;
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    // interrupt mask
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            irq_mask_r <= rct_pkg::RST_IRQ_MASK;
        end else if (reg_wr && (reg_addr == rct_pkg::ADDR_IRQ_MASK)) begin
            irq_mask_r <= reg_wdata;
        end
    end

    // registered outputs; irq lags status by one cycle
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            irq <= 1'h0;
            priority_levels_enable <= 1'h0;
            brownout_detect_en <= 1'h0;
        end else begin
            irq <= |(irq_status & irq_mask_r);
            priority_levels_enable <= prio_en_r;
            brownout_detect_en <= bor_active;
        end
    end
endmodule // rct_reset_track
`default_nettype wire

// >>> tb/rct_reset_track_asserts.sv
// Purpose: port checks for the reset cause tracking block
// Assumes: one clock; rstn is the power-on reset
// Notes: flags are seen only through register reads
`timescale 1ns/1ns
`default_nettype none
module rct_reset_track_asserts (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic [1:0] brownout_mode_cfg,
    input wire logic evt_watchdog_timeout,
    input wire logic evt_reset_instr,
    input wire logic evt_stack_under,
    input wire logic evt_watchdog_clear_instr,
    input wire logic evt_sleep_instr,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic priority_levels_enable,
    input wire logic irq
);
    // ****************************************
    // properties
    // ****************************************
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    logic ctrl_rd;
    logic ctrl_wr;
    // reads and writes of the control register
    assign ctrl_rd = reg_rd && reg_addr == rct_pkg::ADDR_CTRL;
    assign ctrl_wr = reg_wr && reg_addr == rct_pkg::ADDR_CTRL;
    cause_logged_a: assert property (
        reg_rd && reg_addr == rct_pkg::ADDR_IRQ_STATUS
        && $past(evt_stack_under) |=> reg_rdata[7])
        else $error("stack underflow cause not logged");
    unimpl_zero_a: assert property (ctrl_rd |=> !reg_rdata[5])
        else $error("bit 5 reads one");
    instr_clear_a: assert property (
        ctrl_rd && $past(evt_reset_instr) |=> !reg_rdata[4])
        else $error("reset instruction flag not cleared");
    // a flag set by software must be seen on the very next read
    rearm_flag_a: assert property (
        ctrl_wr && reg_wdata[4] && !evt_reset_instr ##1
        ctrl_rd && !evt_reset_instr |=> reg_rdata[4])
        else $error("software could not set the flag");
    prio_follow_a: assert property (
        ctrl_wr |-> ##2 priority_levels_enable == $past(reg_wdata[7], 2))
        else $error("priority enable does not follow bit 7");
    soft_bor_zero_a: assert property (
        ctrl_rd && brownout_mode_cfg != rct_pkg::BOR_MODE_SOFT
        |=> !reg_rdata[6])
        else $error("soft brown-out bit reads one outside mode 01");
    timeout_clr_a: assert property (
        ctrl_rd && $past(evt_watchdog_timeout)
        && !$past(evt_watchdog_clear_instr) && !$past(evt_sleep_instr)
        |=> !reg_rdata[3]) else $error("time-out flag not cleared");
    sleep_clr_a: assert property (
        ctrl_rd && $past(evt_sleep_instr) && !$past(evt_watchdog_clear_instr)
        |=> !reg_rdata[2] && reg_rdata[3])
        else $error("sleep did not update power-down flags");
    // main scenarios reached
    cover property ($rose(irq));
    cover property (ctrl_rd && $past(evt_reset_instr));
    cover property ($rose(priority_levels_enable));
endmodule // rct_reset_track_asserts
bind rct_reset_track rct_reset_track_asserts u_chk (.*);
`default_nettype wire

// >>> tb/tb.sv
// Purpose: directed bench for the reset cause tracking block
// Assumes: register port answers one cycle after the read strobe
// Notes: events are one-cycle pulses driven from the ev vector
`timescale 1ns/1ns
`default_nettype none
module tb;
    logic clk_sys, rstn, sleep_mode, reg_wr, reg_rd, prio, bor_en, irq;
    logic [1:0] cfg;
    logic [8:0] ev;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata;
    int errors, checked, cyc;
    // cause events in the loop and the status bit each one sets
    localparam int EVI [5] = '{0, 1, 4, 5, 6};
    localparam int CB [5] = '{1, 3, 5, 6, 7};
    rct_reset_track dut (.clk_sys(clk_sys), .rstn(rstn),
        .brownout_mode_cfg(cfg), .sleep_mode(sleep_mode),
        .evt_pin_reset(ev[0]), .evt_watchdog_reset(ev[1]),
        .evt_watchdog_timeout(ev[2]), .evt_brownout_reset(ev[3]),
        .evt_reset_instr(ev[4]), .evt_stack_full(ev[5]),
        .evt_stack_under(ev[6]), .evt_watchdog_clear_instr(ev[7]),
        .evt_sleep_instr(ev[8]), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .priority_levels_enable(prio),
        .brownout_detect_en(bor_en), .irq(irq));
    // ****************************************
    // clock and hang guard
    // ****************************************
    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end
    // a stuck run is cut short well past the expected length
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 3000) begin
            errors++;
            $display("[ERR] %0t run did not finish", $time);
            print_verdict();
        end
    end
    // ****************************************
    // access tasks
    // ****************************************
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        checked++;
        if (g !== e) begin
            errors++;
            $display("[ERR] %0t got %h expected %h", $time, g, e);
        end
    endtask
    // strobe is lowered by the next call, so a read may follow at once
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        ev <= 9'h000;
    endtask
    // data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        reg_wr <= 1'b0;
        ev <= 9'h000;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, e);
    endtask
    // event stands one cycle; the read that follows lowers it
    task automatic pulse(input int k);
        @(posedge clk_sys);
        ev <= 9'h001 << k;
        reg_wr <= 1'b0;
    endtask
    task automatic do_reset(input logic [1:0] m);
        @(posedge clk_sys);
        cfg <= m;
        rstn <= 1'b0;
        repeat (20) @(posedge clk_sys);
        rstn <= 1'b1;
    endtask
    task automatic print_verdict();
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // ****************************************
    // tests
    // ****************************************
    initial begin
        {rstn, cfg, sleep_mode, reg_wr, reg_rd, ev, reg_addr, reg_wdata} = '0;
        errors = 0;
        checked = 0;
        cyc = 0;
        do_reset(rct_pkg::BOR_MODE_OFF);
        rd(rct_pkg::ADDR_CTRL, 8'h1C);
        rd(rct_pkg::ADDR_CAUSE, 8'h01);
        wr(rct_pkg::ADDR_CTRL, 8'hFF);
        rd(rct_pkg::ADDR_CTRL, 8'h9F);
        chk({7'h00, prio}, 8'h01);
        wr(rct_pkg::ADDR_CTRL, 8'h00);
        rd(rct_pkg::ADDR_CTRL, 8'h0C);
        wr(rct_pkg::ADDR_CTRL, 8'h13);
        rd(rct_pkg::ADDR_CTRL, 8'h1F);
        pulse(8);
        rd(rct_pkg::ADDR_CTRL, 8'h1B);
        pulse(2);
        rd(rct_pkg::ADDR_CTRL, 8'h13);
        pulse(7);
        rd(rct_pkg::ADDR_CTRL, 8'h1F);
        pulse(4);
        rd(rct_pkg::ADDR_CTRL, 8'h0F);
        $display("flag test done");
        // interrupt raised, masked and cleared
        chk({7'h00, irq}, 8'h00);
        wr(rct_pkg::ADDR_IRQ_MASK, 8'h20);
        rd(rct_pkg::ADDR_IRQ_STATUS, 8'h21);
        chk({7'h00, irq}, 8'h01);
        wr(rct_pkg::ADDR_IRQ_MASK, 8'h00);
        rd(rct_pkg::ADDR_IRQ_MASK, 8'h00);
        chk({7'h00, irq}, 8'h00);
        wr(rct_pkg::ADDR_IRQ_MASK, 8'h20);
        wr(rct_pkg::ADDR_IRQ_STATUS, 8'h20);
        rd(rct_pkg::ADDR_IRQ_STATUS, 8'h01);
        chk({7'h00, irq}, 8'h00);
        wr(4'hF, 8'hFF);
        rd(4'hF, 8'h00);
        $display("interrupt test done");
        // each cause logged alone after clearing the status
        for (int i = 0; i < 5; i++) begin
            wr(rct_pkg::ADDR_IRQ_STATUS, 8'hFF);
            pulse(EVI[i]);
            rd(rct_pkg::ADDR_IRQ_STATUS, 8'h01 << CB[i]);
        end
        @(posedge clk_sys);
        sleep_mode <= 1'b1;
        wr(rct_pkg::ADDR_IRQ_STATUS, 8'hFF);
        pulse(0);
        rd(rct_pkg::ADDR_IRQ_STATUS, 8'h04);
        rd(rct_pkg::ADDR_CTRL, 8'h07);
        $display("cause test done");
        do_reset(rct_pkg::BOR_MODE_SOFT);
        rd(rct_pkg::ADDR_CTRL, 8'h5C);
        chk({7'h00, bor_en}, 8'h01);
        wr(rct_pkg::ADDR_CTRL, 8'h53);
        rd(rct_pkg::ADDR_CTRL, 8'h5F);
        wr(rct_pkg::ADDR_IRQ_STATUS, 8'hFF);
        pulse(3);
        rd(rct_pkg::ADDR_CTRL, 8'h5E);
        rd(rct_pkg::ADDR_IRQ_STATUS, 8'h10);
        wr(rct_pkg::ADDR_CTRL, 8'h13);
        rd(rct_pkg::ADDR_CTRL, 8'h1F);
        chk({7'h00, bor_en}, 8'h00);
        pulse(3);
        rd(rct_pkg::ADDR_CTRL, 8'h1F);
        $display("brown-out test done");
        // hardware modes: bit 6 ignored; detection follows sleep in mode 10, always on in mode 11
        do_reset(rct_pkg::BOR_MODE_NOSLEEP);
        rd(rct_pkg::ADDR_CTRL, 8'h1C);
        wr(rct_pkg::ADDR_CTRL, 8'h53);
        rd(rct_pkg::ADDR_CTRL, 8'h1F);
        chk({7'h00, bor_en}, 8'h00);
        pulse(3);
        rd(rct_pkg::ADDR_CTRL, 8'h1F);
        @(posedge clk_sys);
        sleep_mode <= 1'b0;
        pulse(3);
        rd(rct_pkg::ADDR_CTRL, 8'h1E);
        do_reset(rct_pkg::BOR_MODE_ON);
        rd(rct_pkg::ADDR_CTRL, 8'h1C);
        chk({7'h00, bor_en}, 8'h01);
        $display("mode test done");
        print_verdict();
    end
endmodule // tb
`default_nettype wire
